// [sdr_pkg.sv]
// sdr_pkg: constants shared by the sampling clock delay ramp control block
// assumes: included before every sdr module; apb word-aligned register map
package sdr_pkg;

	// ********************************************************
	// register offsets
	// ********************************************************
	localparam logic [11:0] SDR_OFS_CTRL    = 12'h000;
	localparam logic [11:0] SDR_OFS_TAD     = 12'h004;
	localparam logic [11:0] SDR_OFS_STATUS  = 12'h008;
	localparam logic [11:0] SDR_OFS_SRCOUNT = 12'h00C;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int SDR_CTRL_SINGLE_BIT  = 0;
	localparam int SDR_CTRL_PROC_BIT    = 1;
	localparam int SDR_FINE_DELAY_CODE_LSB     = 0;
	localparam int SDR_COARSE_DELAY_CODE_LSB   = 8;
	localparam int SDR_CLOCK_INVERT_HALF_PERIOD_BIT      = 16;
	localparam int SDR_RAMP_ENABLE_BIT  = 17;
	localparam int SDR_DELAY_RAMP_FUNCTION_SPD_BIT = 18;
	localparam int SDR_ST_ACTIVE_LSB    = 0;
	localparam int SDR_ST_BUSY_BIT      = 8;
	localparam int SDR_ST_DONE_BIT      = 9;
	localparam int SDR_ST_SYSREF_BIT    = 10;

	// ********************************************************
	// widths and reset values
	// ********************************************************
	localparam int          SDR_CODE_W       = 8;
	localparam int          SDR_SRCNT_W      = 16;
	localparam logic [7:0]  SDR_COARSE_RST   = 8'h00;
	localparam logic [7:0]  SDR_FINE_RST     = 8'h00;
	localparam logic        SDR_SINGLE_RST   = 1'b0;
	localparam logic        SDR_PROC_RST     = 1'b1;

	// ********************************************************
	// ramp timing
	// ********************************************************
	localparam int SDR_RAMP_WINDOW     = 384;
	localparam int SDR_RAMP_SLOW_STEPS = 1;
	localparam int SDR_RAMP_FAST_STEPS = 4;
	localparam int SDR_RAMP_SLOW_CYC   = SDR_RAMP_WINDOW / SDR_RAMP_SLOW_STEPS;
	localparam int SDR_RAMP_FAST_CYC   = SDR_RAMP_WINDOW / SDR_RAMP_FAST_STEPS;
	localparam int SDR_RAMP_CNT_W      = 9;

	typedef enum logic {
		SDR_RAMP_IDLE,
		SDR_RAMP_RUN
	} sdr_ramp_state_t;

endpackage

// [sdr_ramp.sv]
// sdr_ramp: steps the active coarse delay code toward a written target
// assumes: load is a one-cycle pulse from the register write decode
`timescale 1ns/1ps
module sdr_ramp #(
	parameter int CODE_W = sdr_pkg::SDR_CODE_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              ramp_enable,
	input  wire logic              ramp_speed_select,
	input  wire logic              load,
	input  wire logic [CODE_W-1:0] target,
	output logic      [CODE_W-1:0] active_code,
	output logic                   busy,
	output logic                   done_pulse
);
	import sdr_pkg::*;

	localparam logic [SDR_RAMP_CNT_W-1:0] SLOW_LAST = SDR_RAMP_CNT_W'(SDR_RAMP_SLOW_CYC - 1);
	localparam logic [SDR_RAMP_CNT_W-1:0] FAST_LAST = SDR_RAMP_CNT_W'(SDR_RAMP_FAST_CYC - 1);

	sdr_ramp_state_t     state_ff;
	logic [CODE_W-1:0]   target_ff;
	logic [CODE_W-1:0]   active_ff;
	logic [SDR_RAMP_CNT_W-1:0] cnt_ff;
	logic                done_ff;
	logic                step_due;
	logic [CODE_W-1:0]   nxt_active;

	// ********************************************************
	// step timing
	// ********************************************************
	assign step_due = ramp_speed_select ? (cnt_ff >= FAST_LAST) : (cnt_ff >= SLOW_LAST);

	always_comb begin
		nxt_active = active_ff;
		if (active_ff < target_ff) begin
			nxt_active = active_ff + CODE_W'(1);
		end else if (active_ff > target_ff) begin
			nxt_active = active_ff - CODE_W'(1);
		end
	end

	// ********************************************************
	// ramp engine
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff  <= SDR_RAMP_IDLE;
			target_ff <= CODE_W'(SDR_COARSE_RST);
			active_ff <= CODE_W'(SDR_COARSE_RST);
			cnt_ff    <= '0;
			done_ff   <= 1'b0;
		end else if (ce) begin
			done_ff <= 1'b0;
			if (load && !ramp_enable) begin
				target_ff <= target;
				active_ff <= target;
				state_ff  <= SDR_RAMP_IDLE;
			end else if (load) begin
				target_ff <= target;
				cnt_ff    <= '0;
				state_ff  <= (target == active_ff) ? SDR_RAMP_IDLE : SDR_RAMP_RUN;
				done_ff   <= (target == active_ff);
			end else begin
				unique case (state_ff)
					SDR_RAMP_IDLE: begin
						cnt_ff <= '0;
					end
					SDR_RAMP_RUN: begin
						if (!ramp_enable) begin
							active_ff <= target_ff;
							state_ff  <= SDR_RAMP_IDLE;
							done_ff   <= 1'b1;
						end else if (step_due) begin
							cnt_ff    <= '0;
							active_ff <= nxt_active;
							if (nxt_active == target_ff) begin
								state_ff <= SDR_RAMP_IDLE;
								done_ff  <= 1'b1;
							end
						end else begin
							cnt_ff <= cnt_ff + SDR_RAMP_CNT_W'(1);
						end
					end
				endcase
			end
		end
	end

	assign active_code = active_ff;
	assign busy        = (state_ff == SDR_RAMP_RUN);
	assign done_pulse  = done_ff;

endmodule

// [sdr_clock_ctrl.sv]
// sdr_clock_ctrl: sampling clock mode, aperture delay and sysref capture control
// assumes: apb master on pclk; sysref_in synchronous to pclk (device clock)
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module sdr_clock_ctrl #(
	parameter int CODE_W  = sdr_pkg::SDR_CODE_W,
	parameter int SRCNT_W = sdr_pkg::SDR_SRCNT_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              sysref_in,
	output logic                   sample_on_rise,
	output logic                   sample_on_fall,
	output logic                   proc_timing_en,
	output logic                   serializer_timing_en,
	output logic                   clock_invert_half_period,
	output logic      [CODE_W-1:0] coarse_delay_code,
	output logic      [CODE_W-1:0] fine_delay_code,
	output logic                   ramp_busy,
	output logic                   sysref_capture,
	output logic                   sysref_capture_shifted
);
	import sdr_pkg::*;

	// ********************************************************
	// declarations
	// ********************************************************
	logic                link_mode_select_ff;
	logic                proc_enable_ff;
	logic [CODE_W-1:0]   fine_ff;
	logic [CODE_W-1:0]   coarse_target_ff;
	logic                invert_ff;
	logic                ramp_enable_ff;
	logic                ramp_speed_ff;
	logic                ramp_done_ff;
	logic                sysref_seen_ff;
	logic [SRCNT_W-1:0]  sysref_count_ff;
	logic                sysref_prev_ff;
	logic                sysref_cap_ff;
	logic                sysref_shift_ff;
	logic                rise_ff;
	logic                fall_ff;
	logic                proc_ff;
	logic                ser_ff;
	logic [31:0]         prdata_ff;
	logic                slverr_ff;
	logic                access;
	logic                wr_en;
	logic                rd_en;
	logic                hit;
	logic                coarse_load;
	logic [CODE_W-1:0]   active_coarse;
	logic                ramp_done_pulse;
	logic                sysref_edge;
	logic [31:0]         nxt_prdata;

	// ********************************************************
	// apb decode
	// ********************************************************
	assign access = psel && penable && ce;
	assign hit    = (paddr == SDR_OFS_CTRL) || (paddr == SDR_OFS_TAD) ||
	                (paddr == SDR_OFS_STATUS) || (paddr == SDR_OFS_SRCOUNT);
	assign wr_en  = access && pwrite && hit;
	assign rd_en  = access && !pwrite && hit;
	assign pready = ce;
	assign coarse_load = wr_en && (paddr == SDR_OFS_TAD);

	// ********************************************************
	// control register
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_mode_select_ff <= SDR_SINGLE_RST;
			proc_enable_ff      <= SDR_PROC_RST;
		end else if (wr_en && (paddr == SDR_OFS_CTRL)) begin
			link_mode_select_ff <= pwdata[SDR_CTRL_SINGLE_BIT];
			proc_enable_ff      <= pwdata[SDR_CTRL_PROC_BIT];
		end
	end

	// ********************************************************
	// aperture delay register
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fine_ff          <= CODE_W'(SDR_FINE_RST);
			coarse_target_ff <= CODE_W'(SDR_COARSE_RST);
			invert_ff        <= 1'b0;
			ramp_enable_ff   <= 1'b0;
			ramp_speed_ff    <= 1'b0;
		end else if (coarse_load) begin
			fine_ff          <= pwdata[SDR_FINE_DELAY_CODE_LSB +: CODE_W];
			coarse_target_ff <= pwdata[SDR_COARSE_DELAY_CODE_LSB +: CODE_W];
			invert_ff        <= pwdata[SDR_CLOCK_INVERT_HALF_PERIOD_BIT];
			ramp_enable_ff   <= pwdata[SDR_RAMP_ENABLE_BIT];
			ramp_speed_ff    <= pwdata[SDR_DELAY_RAMP_FUNCTION_SPD_BIT];
		end
	end

	// ********************************************************
	// coarse delay ramp
	// ********************************************************
	sdr_ramp #(
		.CODE_W (CODE_W)
	) u_ramp (
		.pclk              (pclk),
		.presetn           (presetn),
		.ce                (ce),
		// bus data only counts at the load edge, the stored bit holds afterwards
		.ramp_enable       (coarse_load ? pwdata[SDR_RAMP_ENABLE_BIT] : ramp_enable_ff),
		.ramp_speed_select (ramp_speed_ff),
		.load              (coarse_load),
		.target            (pwdata[SDR_COARSE_DELAY_CODE_LSB +: CODE_W]),
		.active_code       (active_coarse),
		.busy              (),
		.done_pulse        (ramp_done_pulse)
	);

	// ********************************************************
	// status flags
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_done_ff   <= 1'b0;
			sysref_seen_ff <= 1'b0;
		end else if (ce) begin
			if (ramp_done_pulse) begin
				ramp_done_ff <= 1'b1;
			end else if (wr_en && (paddr == SDR_OFS_STATUS) && pwdata[SDR_ST_DONE_BIT]) begin
				ramp_done_ff <= 1'b0;
			end
			if (sysref_edge) begin
				sysref_seen_ff <= 1'b1;
			end else if (wr_en && (paddr == SDR_OFS_STATUS) && pwdata[SDR_ST_SYSREF_BIT]) begin
				sysref_seen_ff <= 1'b0;
			end
		end
	end

	// ********************************************************
	// sysref capture
	// ********************************************************
	// rising-edge only capture keeps the full clock period as window
	assign sysref_edge = sysref_in && !sysref_prev_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysref_prev_ff  <= 1'b0;
			sysref_cap_ff   <= 1'b0;
			sysref_shift_ff <= 1'b0;
			sysref_count_ff <= '0;
		end else if (ce) begin
			sysref_prev_ff  <= sysref_in;
			sysref_cap_ff   <= sysref_edge;
			if (sysref_edge) begin
				sysref_shift_ff <= invert_ff;
				sysref_count_ff <= sysref_count_ff + SRCNT_W'(1);
			end
		end
	end

	// ********************************************************
	// sampling and timing strobes
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
			proc_ff <= 1'b0;
			ser_ff  <= 1'b0;
		end else if (ce) begin
			rise_ff <= 1'b1;
			fall_ff <= link_mode_select_ff;
			proc_ff <= proc_enable_ff;
			ser_ff  <= proc_enable_ff;
		end
	end

	// ********************************************************
	// read data
	// ********************************************************
	always_comb begin
		nxt_prdata = 32'h00000000;
		unique case (paddr)
			SDR_OFS_CTRL: begin
				nxt_prdata[SDR_CTRL_SINGLE_BIT] = link_mode_select_ff;
				nxt_prdata[SDR_CTRL_PROC_BIT]   = proc_enable_ff;
			end
			SDR_OFS_TAD: begin
				nxt_prdata[SDR_FINE_DELAY_CODE_LSB +: CODE_W]   = fine_ff;
				nxt_prdata[SDR_COARSE_DELAY_CODE_LSB +: CODE_W] = coarse_target_ff;
				nxt_prdata[SDR_CLOCK_INVERT_HALF_PERIOD_BIT]              = invert_ff;
				nxt_prdata[SDR_RAMP_ENABLE_BIT]          = ramp_enable_ff;
				nxt_prdata[SDR_DELAY_RAMP_FUNCTION_SPD_BIT]         = ramp_speed_ff;
			end
			SDR_OFS_STATUS: begin
				nxt_prdata[SDR_ST_ACTIVE_LSB +: CODE_W] = active_coarse;
				nxt_prdata[SDR_ST_BUSY_BIT]             = (active_coarse != coarse_target_ff);
				nxt_prdata[SDR_ST_DONE_BIT]             = ramp_done_ff;
				nxt_prdata[SDR_ST_SYSREF_BIT]           = sysref_seen_ff;
			end
			SDR_OFS_SRCOUNT: begin
				nxt_prdata[SRCNT_W-1:0] = sysref_count_ff;
			end
			default: begin
				nxt_prdata = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
			slverr_ff <= 1'b0;
		end else if (ce && psel && !penable) begin
			prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
			slverr_ff <= !hit;
		end
	end

	assign prdata  = rd_en ? prdata_ff : 32'h00000000;
	assign pslverr = access && slverr_ff;

	// ********************************************************
	// delay outputs
	// ********************************************************
	// all three delay controls drive the analog path side by side
	assign clock_invert_half_period = invert_ff;
	assign coarse_delay_code        = active_coarse;
	assign fine_delay_code          = fine_ff;
	assign ramp_busy                = (active_coarse != coarse_target_ff);
	assign sample_on_rise           = rise_ff;
	assign sample_on_fall           = fall_ff;
	assign proc_timing_en           = proc_ff;
	assign serializer_timing_en     = ser_ff;
	assign sysref_capture           = sysref_cap_ff;
	assign sysref_capture_shifted   = sysref_shift_ff;

endmodule

// [sdr_clock_ctrl_asserts.sv]
// sdr_clock_ctrl_asserts: port checks for the clock control block
// assumes: bound into sdr_clock_ctrl, one pclk domain
`timescale 1ns/1ps
module sdr_clock_ctrl_asserts #(
	parameter int CODE_W  = sdr_pkg::SDR_CODE_W,
	parameter int SRCNT_W = sdr_pkg::SDR_SRCNT_W
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              ce,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              sysref_in,
	input wire logic              sample_on_rise,
	input wire logic              sample_on_fall,
	input wire logic              proc_timing_en,
	input wire logic              serializer_timing_en,
	input wire logic              clock_invert_half_period,
	input wire logic [CODE_W-1:0] coarse_delay_code,
	input wire logic [CODE_W-1:0] fine_delay_code,
	input wire logic              ramp_busy,
	input wire logic              sysref_capture,
	input wire logic              sysref_capture_shifted
);
	import sdr_pkg::*;
	// ****************************************
	// helper state
	// ****************************************
	logic              wr_ctl;
	logic              wr_tad;
	logic              fast_ff;
	logic [CODE_W-1:0] tgt_ff;
	logic [CODE_W-1:0] prev_ff;
	logic [9:0]        gap_ff;
	assign wr_ctl = psel && penable && pwrite && ce && paddr == SDR_OFS_CTRL;
	assign wr_tad = psel && penable && pwrite && ce && paddr == SDR_OFS_TAD;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt_ff  <= '0;
			fast_ff <= 1'b0;
		end else if (wr_tad) begin
			tgt_ff  <= pwdata[8 +: CODE_W];
			fast_ff <= pwdata[SDR_DELAY_RAMP_FUNCTION_SPD_BIT];
		end
	end
	// cycles since the last delay write or coarse change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff <= '0;
			gap_ff  <= '0;
		end else if (ce) begin
			prev_ff <= coarse_delay_code;
			if (wr_tad)
				gap_ff <= '0;
			else if (coarse_delay_code != prev_ff)
				gap_ff <= 10'h001;
			else
				gap_ff <= gap_ff + 10'h001;
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rise; $past(presetn) && $past(ce) |-> sample_on_rise; endproperty
	a_rise: assert property (p_rise) else $error("rise sampling off");
	property p_fall; wr_ctl |-> ##2 sample_on_fall == $past(pwdata[0], 2); endproperty
	a_fall: assert property (p_fall) else $error("dual-edge mode wrong");
	property p_proc; wr_ctl |-> ##2 proc_timing_en == $past(pwdata[1], 2) && serializer_timing_en == proc_timing_en;
	endproperty
	a_proc: assert property (p_proc) else $error("processing timing wrong");
	property p_tad; wr_tad |=> clock_invert_half_period == $past(pwdata[16]) && fine_delay_code == $past(pwdata[7:0]);
	endproperty
	a_tad: assert property (p_tad) else $error("invert or fine wrong");
	property p_direct; wr_tad && !pwdata[17] |=> coarse_delay_code == $past(pwdata[15:8]); endproperty
	a_direct: assert property (p_direct) else $error("direct coarse wrong");
	property p_step; !$past(wr_tad) && $changed(coarse_delay_code) |->
		gap_ff == (fast_ff ? SDR_RAMP_FAST_CYC : SDR_RAMP_SLOW_CYC) && (tgt_ff > $past(coarse_delay_code) ?
		coarse_delay_code == $past(coarse_delay_code) + 1'b1 : coarse_delay_code == $past(coarse_delay_code) - 1'b1);
	endproperty
	a_step: assert property (p_step) else $error("ramp step wrong");
	property p_busy; ramp_busy == (coarse_delay_code != tgt_ff); endproperty
	a_busy: assert property (p_busy) else $error("ramp busy wrong");
	property p_cap; $rose(sysref_in) |=> sysref_capture ##1 !sysref_capture; endproperty
	a_cap: assert property (p_cap) else $error("sysref capture wrong");
	property p_shift; $rose(sysref_in) |=> sysref_capture_shifted == $past(clock_invert_half_period); endproperty
	a_shift: assert property (p_shift) else $error("sysref shift wrong");
endmodule
bind sdr_clock_ctrl sdr_clock_ctrl_asserts #(.CODE_W(CODE_W), .SRCNT_W(SRCNT_W)) u_sdr_clock_ctrl_asserts (
	.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.sysref_in, .sample_on_rise, .sample_on_fall, .proc_timing_en, .serializer_timing_en,
	.clock_invert_half_period, .coarse_delay_code, .fine_delay_code, .ramp_busy,
	.sysref_capture, .sysref_capture_shifted
);

// [sdr_clkgen_model.sv]
// sdr_clkgen_model: external clock generator model driving sysref
// assumes: device clock is pclk; sysref launched just after a rising edge
`timescale 1ns/1ps
module sdr_clkgen_model #(
	parameter int PERIOD = 8 // multiframe clock divided by an integer
) (
	input  wire logic pclk,
	output logic      sysref_in
);
	initial sysref_in = 1'b0;
	// n sysref cycles, hi clocks high; n of 1 gives a single pulse
	task automatic burst(input int n, input int hi);
		repeat (n) begin
			@(posedge pclk);
			sysref_in <= 1'b1; // whole-cycle setup and hold to pclk
			repeat (hi) @(posedge pclk);
			sysref_in <= 1'b0;
			repeat (PERIOD - hi - 1) @(posedge pclk);
		end
	endtask
endmodule

// [testbench.sv]
// testbench: apb sequences with expected values for the clock control block
// assumes: package, design, checker and clock generator model compiled first
`timescale 1ns/1ps
module testbench;
	import sdr_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        sysref_in, sample_on_rise, sample_on_fall, proc_timing_en, serializer_timing_en;
	logic        clock_invert_half_period, ramp_busy, sysref_capture, sysref_capture_shifted;
	logic [7:0]  coarse_delay_code, fine_delay_code;
	logic [31:0] tad [4] = '{32'h0001_FF00, 32'h0000_00FF, 32'h0001_A55A, 32'h0};
	int          n_mismatch = 0, compares = 0, ncap = 0;
	sdr_clock_ctrl u_sdr_clock_ctrl (
		.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sysref_in, .sample_on_rise, .sample_on_fall, .proc_timing_en, .serializer_timing_en,
		.clock_invert_half_period, .coarse_delay_code, .fine_delay_code, .ramp_busy,
		.sysref_capture, .sysref_capture_shifted
	);
	sdr_clkgen_model u_sdr_clkgen_model (.pclk, .sysref_in);
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) if (sysref_capture === 1'b1) ncap <= ncap + 1;
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask
	task automatic final_report;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		#100000;
		n_mismatch++;
		final_report;
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'({sample_on_rise, proc_timing_en, serializer_timing_en}), 32'h7);
		rdc(SDR_OFS_CTRL, 32'h2);
		wr(12'h010, 32'hFFFF_FFFF);
		chk(32'(er), 32'h1);
		rdc(SDR_OFS_TAD, 32'h0);
		chk(32'(er), 32'h0);
		rdc(12'h010, 32'h0);
		wr(SDR_OFS_CTRL, 32'h1);
		repeat (2) @(posedge pclk);
		chk(32'({sample_on_rise, sample_on_fall, proc_timing_en, serializer_timing_en}), 32'hC);
		wr(SDR_OFS_CTRL, 32'h2);
		repeat (2) @(posedge pclk);
		chk(32'({sample_on_rise, sample_on_fall, proc_timing_en, serializer_timing_en}), 32'hB);
		foreach (tad[i]) begin
			wr(SDR_OFS_TAD, tad[i]);
			repeat (2) @(posedge pclk);
			chk(32'({clock_invert_half_period, coarse_delay_code, fine_delay_code}), tad[i]);
			rdc(SDR_OFS_TAD, tad[i]);
		end
		wr(SDR_OFS_TAD, 32'h0006_0200);
		repeat (100) @(posedge pclk);
		chk(32'({ramp_busy, coarse_delay_code}), 32'h101);
		repeat (100) @(posedge pclk);
		rdc(SDR_OFS_STATUS, 32'h202);
		wr(SDR_OFS_STATUS, 32'h200);
		rdc(SDR_OFS_STATUS, 32'h002);
		wr(SDR_OFS_TAD, 32'h0002_0000);
		repeat (390) @(posedge pclk);
		chk(32'({ramp_busy, coarse_delay_code}), 32'h101);
		wr(SDR_OFS_TAD, 32'h0006_0300);
		repeat (200) @(posedge pclk);
		chk(32'({ramp_busy, coarse_delay_code}), 32'h003);
		wr(SDR_OFS_TAD, 32'h0006_1000);
		repeat (10) @(posedge pclk);
		wr(SDR_OFS_TAD, 32'h0001_2000);
		repeat (2) @(posedge pclk);
		chk(32'({ramp_busy, coarse_delay_code}), 32'h020);
		u_sdr_clkgen_model.burst(1, 1);
		repeat (3) @(posedge pclk);
		chk(ncap, 32'h1);
		u_sdr_clkgen_model.burst(3, 3);
		repeat (3) @(posedge pclk);
		chk(ncap, 32'h4);
		chk(32'(sysref_capture_shifted), 32'h1);
		rdc(SDR_OFS_SRCOUNT, 32'h4);
		xfer(SDR_OFS_STATUS, 1'b0, 32'h0);
		chk(rd & 32'h4FF, 32'h420);
		wr(SDR_OFS_STATUS, 32'h600);
		rdc(SDR_OFS_STATUS, 32'h020);
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(32'({pready, coarse_delay_code}), 32'h020);
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(32'({sample_on_rise, sample_on_fall, proc_timing_en, serializer_timing_en}), 32'h0);
		chk(32'({clock_invert_half_period, coarse_delay_code, fine_delay_code, ramp_busy}), 32'h0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'({sample_on_rise, proc_timing_en, serializer_timing_en}), 32'h7);
		rdc(SDR_OFS_STATUS, 32'h0);
		rdc(SDR_OFS_SRCOUNT, 32'h0);
		u_sdr_clkgen_model.burst(1, 1);
		repeat (3) @(posedge pclk);
		chk(ncap, 32'h5);
		chk(32'(sysref_capture_shifted), 32'h0);
		rdc(SDR_OFS_SRCOUNT, 32'h1);
		repeat (2) @(posedge pclk);
		final_report;
	end
endmodule
